// file: logic/watchdog_control_status.sv
// Watchdog control and status: register, timed changes, counter
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

module watchdog_control_status
#(
   parameter int unsigned OSC_DIV = `WDT_OSC_DIV
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire wdt_pkg::wdt_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic safety_level_fuse,
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   input wire logic kick_instruction,
   output wdt_pkg::wdt_core_out_t core_out
);

   // ==================================================================
   // Prescaler decode
   function automatic logic [19:0] terminal_count(input logic [3:0] sel);
      logic [3:0] code;
      logic [20:0] full;
      code = (sel > `WDT_PRESC_MAX) ? `WDT_PRESC_MAX : sel;
      full = (`WDT_BASE_TERMINAL << code) - 21'h000001;
      return full[19:0];
   endfunction

   // ==================================================================
   // Register select decode
   function automatic logic reg_hit(input logic [1:0] addr,
      input logic [1:0] offset);
      return addr == offset;
   endfunction

   // ==================================================================
   // State
   logic timeout_irq_flag;
   logic timeout_irq_enable;
   logic reset_enable_stored;
   logic [3:0] prescale_select;
   logic watchdog_reset_flag;
   logic safety_level_two;
   logic fuse_taken;
   logic [19:0] wdog_count;
   logic change_enable;
   logic osc_tick;

   logic next_timeout_irq_flag;
   logic next_timeout_irq_enable;
   logic next_reset_enable;
   logic [3:0] next_prescale_select;
   logic next_watchdog_reset_flag;
   logic [19:0] next_wdog_count;
   logic [7:0] next_rdata;

   wdt_pkg::wdt_mode_t mode;
   logic irq_timeout;
   logic reset_timeout;
   logic running;
   logic irq_request;
   logic chip_reset_pulse;
   logic watchdog_running;
   logic next_irq_request;
   logic next_chip_reset_pulse;
   logic next_watchdog_running;

   // ==================================================================
   // Oscillator tick and change window
   wdt_osc_tick #(
      .OSC_DIV(OSC_DIV)
   ) u_osc_tick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .osc_tick(osc_tick)
   );

   // ==================================================================
   // Bus decode
   wire ctrl_sel = reg_hit(bus_req.addr, `WDT_CTRL_OFFSET);
   wire rstsrc_sel = reg_hit(bus_req.addr, `WDT_RSTSRC_OFFSET);
   wire ctrl_wr = bus_req.wr && ctrl_sel;
   wire rstsrc_wr = bus_req.wr && rstsrc_sel;
   wire ctrl_rd = bus_req.rd && ctrl_sel;
   wire rstsrc_rd = bus_req.rd && rstsrc_sel;

   wire wr_flag_bit = bus_req.wdata[`WDT_BIT_IRQ_FLAG];
   wire wr_irq_enable = bus_req.wdata[`WDT_BIT_IRQ_ENABLE];
   wire wr_change_enable = bus_req.wdata[`WDT_BIT_CHANGE_EN];
   wire wr_reset_enable = bus_req.wdata[`WDT_BIT_RESET_EN];
   wire [3:0] wr_prescale = {bus_req.wdata[`WDT_BIT_PRESC_HI],
      bus_req.wdata[`WDT_PRESC_LO_MSB:0]};
   wire wr_rstsrc_flag = bus_req.wdata[`WDT_BIT_WDOG_RESET_FLAG];

   wire window_open_req = ctrl_wr && wr_change_enable;
   wire window_close_req = ctrl_wr && !wr_change_enable;

   wdt_change_window u_change_window (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .open_req(window_open_req),
      .close_req(window_close_req),
      .window_open(change_enable)
   );

   // ==================================================================
   // Safety level strap, caught once after reset release
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         fuse_taken <= 1'b0;
      else
         fuse_taken <= 1'b1;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         safety_level_two <= 1'b0;
      else if (!fuse_taken)
         safety_level_two <= safety_level_fuse;
   end

   // ==================================================================
   // Mode decode
   wire reset_enable = reset_enable_stored || safety_level_two;

   always_comb
   begin
      unique case ({reset_enable, timeout_irq_enable})
         2'b00: mode = wdt_pkg::MODE_STOPPED;
         2'b01: mode = wdt_pkg::MODE_IRQ;
         2'b10: mode = wdt_pkg::MODE_RESET;
         2'b11: mode = wdt_pkg::MODE_IRQ_THEN_RESET;
      endcase
   end

   wire expiry = running && osc_tick &&
      (wdog_count == terminal_count(prescale_select));

   always_comb
   begin
      running = 1'b1;
      irq_timeout = 1'b0;
      reset_timeout = 1'b0;
      unique case (mode)
         wdt_pkg::MODE_STOPPED:
            running = 1'b0;
         wdt_pkg::MODE_IRQ:
            irq_timeout = expiry;
         wdt_pkg::MODE_RESET:
            reset_timeout = expiry;
         wdt_pkg::MODE_IRQ_THEN_RESET:
            irq_timeout = expiry;
      endcase
   end

   // ==================================================================
   // Next values of the control fields
   // Flag: hardware set wins over either clear
   assign next_timeout_irq_flag = irq_timeout ||
      (timeout_irq_flag && !irq_vector_taken &&
      !(ctrl_wr && wr_flag_bit));

   // Interrupt enable: a write in the timeout cycle wins
   assign next_timeout_irq_enable = ctrl_wr ? wr_irq_enable :
      (timeout_irq_enable && !(irq_timeout && reset_enable));

   // Reset enable: set freely, cleared only in the window
   wire wr_reset_value = wr_reset_enable ||
      (reset_enable_stored && !change_enable);
   assign next_reset_enable = watchdog_reset_flag ||
      safety_level_two ||
      (ctrl_wr ? wr_reset_value : reset_enable_stored);

   assign next_prescale_select = (ctrl_wr && change_enable) ?
      wr_prescale : prescale_select;

   // Reset flag: set wins over a write of zero
   assign next_watchdog_reset_flag = reset_timeout ||
      (watchdog_reset_flag && !(rstsrc_wr && !wr_rstsrc_flag));

   // ==================================================================
   // Counter: oscillator ticks, cleared by kick, disable or expiry
   wire count_clear = !running || kick_instruction || expiry;
   assign next_wdog_count = count_clear ? `WDT_COUNT_RESET :
      (osc_tick ? wdog_count + 20'h00001 : wdog_count);

   // ==================================================================
   // Read data
   wire [7:0] ctrl_view = {timeout_irq_flag, timeout_irq_enable,
      prescale_select[3], change_enable, reset_enable,
      prescale_select[2:0]};
   wire [7:0] rstsrc_view = {4'h0, watchdog_reset_flag, 3'h0};
   assign next_rdata = ctrl_rd ? ctrl_view :
      (rstsrc_rd ? rstsrc_view : 8'h00);

   // ==================================================================
   // Next values of the outputs towards the core
   // Request follows flag, enable and global enable
   assign next_irq_request = timeout_irq_flag &&
      timeout_irq_enable && global_irq_enable;
   // One-cycle pulse on a reset-mode expiry
   assign next_chip_reset_pulse = reset_timeout;
   // Running whenever the mode is not stopped
   assign next_watchdog_running = running;

   // ==================================================================
   // Timeout interrupt flag
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         timeout_irq_flag <= 1'b0;
      else
         timeout_irq_flag <= next_timeout_irq_flag;
   end

   // ==================================================================
   // Timeout interrupt enable
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         timeout_irq_enable <= 1'b0;
      else
         timeout_irq_enable <= next_timeout_irq_enable;
   end

   // ==================================================================
   // Stored reset enable
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         reset_enable_stored <= 1'b0;
      else
         reset_enable_stored <= next_reset_enable;
   end

   // ==================================================================
   // Prescaler select
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         prescale_select <= `WDT_PRESC_RESET;
      else
         prescale_select <= next_prescale_select;
   end

   // ==================================================================
   // Watchdog reset flag
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         watchdog_reset_flag <= 1'b0;
      else
         watchdog_reset_flag <= next_watchdog_reset_flag;
   end

   // ==================================================================
   // Watchdog counter
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         wdog_count <= `WDT_COUNT_RESET;
      else
         wdog_count <= next_wdog_count;
   end

   // ==================================================================
   // Read data
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata <= 8'h00;
      else
         rdata <= next_rdata;
   end

   // ==================================================================
   // Interrupt request
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_request <= 1'b0;
      else
         irq_request <= next_irq_request;
   end

   // ==================================================================
   // Chip reset pulse
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         chip_reset_pulse <= 1'b0;
      else
         chip_reset_pulse <= next_chip_reset_pulse;
   end

   // ==================================================================
   // Running indication
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         watchdog_running <= 1'b0;
      else
         watchdog_running <= next_watchdog_running;
   end

   // ==================================================================
   // Outputs towards the core
   assign core_out = {
      irq_request,
      chip_reset_pulse,
      watchdog_running
   };

endmodule
`default_nettype wire

// file: logic/wdt_params.svh
// Constants for the watchdog control and status block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// =====================================================================
// Register map
`define WDT_ADDR_W 2
`define WDT_CTRL_OFFSET 2'h0
`define WDT_RSTSRC_OFFSET 2'h1

// =====================================================================
// Control register field positions
`define WDT_BIT_IRQ_FLAG 7
`define WDT_BIT_IRQ_ENABLE 6
`define WDT_BIT_PRESC_HI 5
`define WDT_BIT_CHANGE_EN 4
`define WDT_BIT_RESET_EN 3
`define WDT_PRESC_LO_MSB 2

// Reset source register field position
`define WDT_BIT_WDOG_RESET_FLAG 3

// =====================================================================
// Reset values
`define WDT_PRESC_RESET 4'h0
`define WDT_COUNT_RESET 20'h00000

// =====================================================================
// Timing
`define WDT_CLK_PERIOD_PS 5000
`define WDT_OSC_PERIOD_PS 7812500
`define WDT_OSC_DIV (`WDT_OSC_PERIOD_PS / `WDT_CLK_PERIOD_PS)
`define WDT_CHANGE_WINDOW_CYCLES 3'h4
`define WDT_BASE_TERMINAL 21'h000800
`define WDT_PRESC_MAX 4'h9

`endif

// file: logic/wdt_pkg.sv
// Types shared by the watchdog control and status block
package wdt_pkg;

   // ==================================================================
   // Register port request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdt_bus_req_t;

   // ==================================================================
   // Operating mode from the enable pair
   typedef enum logic [1:0] {
      MODE_STOPPED,
      MODE_IRQ,
      MODE_RESET,
      MODE_IRQ_THEN_RESET
   } wdt_mode_t;

   // ==================================================================
   // Outputs towards the processor core
   typedef struct packed {
      logic irq_request;
      logic chip_reset_pulse;
      logic watchdog_running;
   } wdt_core_out_t;

endpackage

// file: logic/wdt_osc_tick.sv
// Watchdog oscillator tick derived from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

module wdt_osc_tick
#(
   parameter int unsigned OSC_DIV = `WDT_OSC_DIV
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   output logic osc_tick
);

   localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

   logic [15:0] div_count;
   wire div_wrap = (div_count == DIV_LAST);

   // ==================================================================
   // Divider
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_count <= 16'h0000;
         osc_tick <= 1'b0;
      end
      else
      begin
         div_count <= div_wrap ? 16'h0000 : div_count + 16'h0001;
         osc_tick <= div_wrap;
      end
   end

endmodule
`default_nettype wire

// file: logic/wdt_change_window.sv
// Timed window opened by the change enable bit
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

module wdt_change_window
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic open_req,
   input wire logic close_req,
   output logic window_open
);

   logic [2:0] remaining;

   // ==================================================================
   // Countdown
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         remaining <= 3'h0;
      else if (open_req)
         remaining <= `WDT_CHANGE_WINDOW_CYCLES;
      else if (close_req)
         remaining <= 3'h0;
      else if (remaining != 3'h0)
         remaining <= remaining - 3'h1;
   end

   assign window_open = (remaining != 3'h0);

endmodule
`default_nettype wire

// file: verification/wdt_ctrl_checker.sv
// Port assertions for the watchdog control and status block
`timescale 1ns/1ps
`default_nettype none
module wdt_ctrl_checker
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire wdt_pkg::wdt_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic safety_level_fuse,
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   input wire wdt_pkg::wdt_core_out_t core_out
);
   logic [2:0] run_cnt;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // ====================
   // Cycles since reset release
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         run_cnt <= 3'h0;
      else if (run_cnt != 3'h7)
         run_cnt <= run_cnt + 3'h1;
   end
   // ====================
   // Relations at the ports
   a_rdata_idle:
   assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_rstsrc_bits:
   assert property ($past(bus_req.rd && bus_req.addr == 2'h1)
      |-> rdata[7:4] == 4'h0 && rdata[2:0] == 3'h0)
      else $error("reset source spare bits set");
   a_irq_global:
   assert property (core_out.irq_request |-> $past(global_irq_enable))
      else $error("interrupt without global enable");
   a_irq_needs_run:
   assert property (core_out.irq_request |-> core_out.watchdog_running)
      else $error("interrupt while stopped");
   a_pulse_single:
   assert property (core_out.chip_reset_pulse |=> !core_out.chip_reset_pulse)
      else $error("reset pulse longer than one cycle");
   a_pulse_needs_run:
   assert property (core_out.chip_reset_pulse
      |-> $past(core_out.watchdog_running))
      else $error("reset pulse while stopped");
   a_vector_clears:
   assert property (irq_vector_taken |-> ##2 !core_out.irq_request)
      else $error("interrupt kept after vector");
   a_level2_on:
   assert property (run_cnt == 3'h7 && safety_level_fuse
      |-> core_out.watchdog_running)
      else $error("stopped in safety level two");
endmodule
bind watchdog_control_status wdt_ctrl_checker u_chk
(
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .bus_req(bus_req),
   .rdata(rdata),
   .safety_level_fuse(safety_level_fuse),
   .global_irq_enable(global_irq_enable),
   .irq_vector_taken(irq_vector_taken),
   .core_out(core_out)
);
`default_nettype wire

// file: verification/test_watchdog_control_status.sv
// Self-checking bench for the watchdog control and status block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_control_status;
   logic ref_clk, reset_n, fuse, gie, vec, kick, wv, lvl2;
   wdt_pkg::wdt_bus_req_t req;
   wdt_pkg::wdt_core_out_t co;
   logic [7:0] rdata, e, mr;
   logic [31:0] rs;
   int failures, compares, cyc, pulses, w0, n;
   watchdog_control_status #(.OSC_DIV(2)) DUT
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .bus_req(req),
      .rdata(rdata),
      .safety_level_fuse(fuse),
      .global_irq_enable(gie),
      .irq_vector_taken(vec),
      .kick_instruction(kick),
      .core_out(co)
   );
   // ====================
   // Clock, timeout, reset pulse count
   initial
   begin
      ref_clk = 1'b0;
      forever
         #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (co.chip_reset_pulse === 1'b1)
         pulses <= pulses + 1;
      if (cyc == 40000)
      begin
         failures = failures + 1;
         complete_run();
      end
   end
   // ====================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      compares = compares + 1;
      if (g !== x)
      begin
         failures = failures + 1;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      logic ok;
      @(posedge ref_clk);
      req <= '{a, d, 1'b1, 1'b0};
      ok = wv && (cyc - w0) inside {[1:4]};
      if (a == 2'h0)
      begin
         e[7] = e[7] & ~d[7];
         e[6] = d[6];
         e[3] = (ok && !lvl2 && !mr[3]) ? d[3] : e[3] | d[3];
         if (ok)
            {e[5], e[2:0]} = {d[5], d[2:0]};
         wv = d[4];
         w0 = cyc;
      end
      if (a == 2'h1)
         mr[3] = mr[3] & d[3];
      @(posedge ref_clk);
      req <= '0;
   endtask
   task automatic rd(input logic [1:0] a);
      logic [7:0] x;
      @(posedge ref_clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      x = (a == 2'h1) ? mr : 8'h00;
      if (a == 2'h0)
         x = {e[7:5], wv && (cyc - w0) inside {[1:4]}, e[3:0]};
      @(posedge ref_clk);
      req <= '0;
      #1 chk(rdata, x);
   endtask
   task automatic do_reset(input logic f);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      fuse <= f;
      idle(4);
      reset_n <= 1'b1;
      e = {4'h0, f, 3'h0};
      mr = 8'h00;
      wv = 1'b0;
      lvl2 = f;
      idle(2);
   endtask
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ====================
   // Main sequence
   initial
   begin
      {reset_n, fuse, gie, vec, kick} = 5'h00;
      req = '0;
      cyc = 0;
      failures = 0;
      compares = 0;
      pulses = 0;
      w0 = 0;
      rs = 32'h2ffcc350;
      do_reset(1'b0);
      rd(2'h0);
      rd(2'h1);
      rs = xs(rs);
      wr({1'b1, rs[0]}, rs[15:8]);
      rd({1'b1, rs[1]});
      rd(2'h0);
      $display("done: reset state");
      wr(2'h0, 8'h08);
      rd(2'h0);
      wr(2'h0, 8'h07);
      rd(2'h0);
      wr(2'h0, 8'h18);
      rd(2'h0);
      wr(2'h0, 8'h2f);
      rd(2'h0);
      wr(2'h0, 8'h18);
      idle(3);
      wr(2'h0, 8'h00);
      rd(2'h0);
      wr(2'h0, 8'h18);
      wr(2'h0, 8'h00);
      rd(2'h0);
      chk({7'h0, co.watchdog_running}, 8'h00);
      $display("done: timed writes");
      gie <= 1'b1;
      wr(2'h0, 8'h40);
      n = 0;
      while (co.irq_request !== 1'b1 && n < 5000)
      begin
         @(posedge ref_clk);
         #1;
         n = n + 1;
      end
      chk({7'h0, n > 4088 && n < 4104}, 8'h01);
      e[7] = 1'b1;
      rd(2'h0);
      @(posedge ref_clk);
      vec <= 1'b1;
      @(posedge ref_clk);
      vec <= 1'b0;
      e[7] = 1'b0;
      rd(2'h0);
      gie <= 1'b0;
      idle(4100);
      e[7] = 1'b1;
      rd(2'h0);
      chk({7'h0, co.irq_request}, 8'h00);
      gie <= 1'b1;
      idle(3);
      chk({7'h0, co.irq_request}, 8'h01);
      wr(2'h0, 8'hc0);
      rd(2'h0);
      $display("done: interrupt mode");
      wr(2'h0, 8'h48);
      idle(4100);
      e[7:6] = 2'b10;
      rd(2'h0);
      idle(4100);
      chk(pulses[7:0], 8'h01);
      mr[3] = 1'b1;
      rd(2'h1);
      wr(2'h0, 8'h88);
      wr(2'h0, 8'h18);
      wr(2'h0, 8'h00);
      rd(2'h0);
      wr(2'h1, 8'h00);
      repeat (3)
      begin
         rs = xs(rs);
         idle(2900 + int'(rs[7:0]));
         kick <= 1'b1;
         @(posedge ref_clk);
         kick <= 1'b0;
      end
      chk(pulses[7:0], 8'h01);
      wr(2'h0, 8'h18);
      wr(2'h0, 8'h00);
      rd(2'h0);
      $display("done: reset mode");
      do_reset(1'b1);
      rd(2'h0);
      wr(2'h0, 8'h18);
      wr(2'h0, 8'h01);
      rd(2'h0);
      chk({7'h0, co.watchdog_running}, 8'h01);
      $display("done: safety level two");
      complete_run();
   end
endmodule
`default_nettype wire
